// [verilog/fbdp_port.sv]
// fbdp_port: pin-level four-bank dram port with shared boot rom and
// palette dac use of the data bus. assumes clk_i is the doubled memory
// clock pin and requests come from logic on the same clock.
`timescale 1ns/1ps
`include "fbdp_map.svh"
module fbdp_port
  import fbdp_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  input wire fbdp_req_type req_i,
  input wire logic join_halves_i,
  input wire logic [31:0] mem_data_bus_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [31:0] rsp_data_o,
  output logic [31:0] mem_data_bus_o,
  output logic [31:0] mem_data_bus_oe_o,
  output logic [8:0] mem_addr_banks_even_pair_o,
  output logic [8:0] mem_addr_banks_odd_pair_o,
  output logic row_strobe_n_o,
  output logic [3:0] col_strobe_even_pair_n_o,
  output logic [3:0] col_strobe_odd_pair_n_o,
  output logic write_en_outer_pair_n_o,
  output logic write_en_inner_pair_n_o,
  output logic [3:0] out_en_bank_n_o,
  output logic boot_rom_select_n_o,
  output logic dac_select_n_o,
  output logic wide_port_join_o
);
  logic phase;
  fbdp_state_type state_reg, state_next;
  fbdp_req_type cur_reg, cur_next;
  logic [3:0] wait_reg, wait_next;
  logic [8:0] addr_even_reg, addr_even_next, addr_odd_reg, addr_odd_next;
  logic ras_n_reg, ras_n_next;
  logic [3:0] cas_even_reg, cas_even_next, cas_odd_reg, cas_odd_next;
  logic write_en_outer_pair_n_reg, write_en_outer_pair_n_next, write_en_inner_pair_n_reg, write_en_inner_pair_n_next;
  logic [3:0] oe_reg, oe_next;
  logic rom_n_reg, rom_n_next, dac_n_reg, dac_n_next;
  logic join_reg, join_next;
  logic [31:0] dout_reg, dout_next;
  logic drive_reg, drive_next;
  logic drive_lo_reg, drive_lo_next;
  logic ready_reg, ready_next, rsp_reg, rsp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] md_meta_reg, md_sync_reg;
  logic odd_bank;
  logic [3:0] bank_hot;

  fbdp_clk_half u_half (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .phase_o(phase)
  );

  // read data from the pins pass two flops before use
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      md_meta_reg <= 32'h0;
      md_sync_reg <= 32'h0;
    end else begin
      md_meta_reg <= mem_data_bus_i;
      md_sync_reg <= md_meta_reg;
    end
  end

  assign odd_bank = cur_reg.bank[0];
  assign bank_hot = 4'h1 << cur_reg.bank;

  // sequencer advances only on the internal half-rate phase
  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    wait_next = wait_reg;
    addr_even_next = addr_even_reg;
    addr_odd_next = addr_odd_reg;
    ras_n_next = ras_n_reg;
    cas_even_next = cas_even_reg;
    cas_odd_next = cas_odd_reg;
    write_en_outer_pair_n_next = write_en_outer_pair_n_reg;
    write_en_inner_pair_n_next = write_en_inner_pair_n_reg;
    oe_next = oe_reg;
    rom_n_next = rom_n_reg;
    dac_n_next = dac_n_reg;
    dout_next = dout_reg;
    drive_next = drive_reg;
    drive_lo_next = drive_lo_reg;
    ready_next = ready_reg;
    rsp_next = 1'b0;
    rdata_next = rdata_reg;
    join_next = ~join_halves_i;
    if (phase) begin
      case (state_reg)
        FBDP_IDLE: begin
          // the next edge is phase low, so ready drops for it
          ready_next = 1'b0;
          if (req_valid_i && ready_reg) begin
            cur_next = req_i;
            ready_next = 1'b0;
            state_next = FBDP_ROW;
            if (req_i.op != FBDP_OP_DRAM) begin
              state_next = FBDP_ROM;
              wait_next = `FBDP_ROM_WAIT;
            end
          end
        end
        FBDP_ROW: begin
          // row on both buses one phase ahead of the strobe
          addr_even_next = cur_reg.addr[`FBDP_ROW_LSB +: `FBDP_ADDR_W];
          addr_odd_next = cur_reg.addr[`FBDP_ROW_LSB +: `FBDP_ADDR_W];
          state_next = FBDP_RAS;
        end
        FBDP_RAS: begin
          ras_n_next = 1'b0;
          state_next = FBDP_COL;
        end
        FBDP_COL: begin
          if (odd_bank) begin
            addr_odd_next = cur_reg.addr[`FBDP_ADDR_W-1:0];
          end else begin
            addr_even_next = cur_reg.addr[`FBDP_ADDR_W-1:0];
          end
          if (cur_reg.write) begin
            // outer pair is banks 0 and 3, inner pair banks 1 and 2
            write_en_outer_pair_n_next = ~(bank_hot[0] | bank_hot[3]);
            write_en_inner_pair_n_next = ~(bank_hot[1] | bank_hot[2]);
            dout_next = cur_reg.wdata;
            drive_next = 1'b1;
            drive_lo_next = 1'b1;
          end else begin
            oe_next = ~bank_hot;
          end
          state_next = FBDP_CAS;
        end
        FBDP_CAS: begin
          if (odd_bank) begin
            cas_odd_next = ~cur_reg.byte_en;
          end else begin
            cas_even_next = ~cur_reg.byte_en;
          end
          state_next = FBDP_DONE;
        end
        FBDP_DONE: begin
          rdata_next = md_sync_reg;
          rsp_next = 1'b1;
          ras_n_next = 1'b1;
          cas_even_next = 4'hf;
          cas_odd_next = 4'hf;
          write_en_outer_pair_n_next = 1'b1;
          write_en_inner_pair_n_next = 1'b1;
          oe_next = 4'hf;
          drive_next = 1'b0;
          drive_lo_next = 1'b0;
          state_next = FBDP_IDLE;
        end
        FBDP_ROM: begin
          // rom and dac share the bus lanes; held for a fixed wait
          drive_next = 1'b1;
          // low lane stays free on rom reads so rom data can return
          drive_lo_next = (cur_reg.op != FBDP_OP_ROM);
          if (cur_reg.op == FBDP_OP_ROM) begin
            rom_n_next = 1'b0;
            dout_next = 32'h0;
            dout_next[`FBDP_ROM_ADDR_MSB:`FBDP_ROM_ADDR_LSB] =
              cur_reg.addr[14:0];
            dout_next[`FBDP_ROM_RW_BIT] = 1'b1;
          end else if (cur_reg.op == FBDP_OP_DAC_REG) begin
            dac_n_next = 1'b0;
            dout_next = 32'h0;
            dout_next[`FBDP_DAC_REG_MSB:`FBDP_DAC_REG_LSB] =
              cur_reg.wdata[7:0];
          end else begin
            dac_n_next = 1'b0;
            dout_next = cur_reg.wdata;
          end
          if (wait_reg == 4'h0) begin
            rdata_next = {24'h0,
              md_sync_reg[`FBDP_ROM_DATA_MSB:`FBDP_ROM_DATA_LSB]};
            rsp_next = 1'b1;
            rom_n_next = 1'b1;
            dac_n_next = 1'b1;
            drive_next = 1'b0;
            drive_lo_next = 1'b0;
            state_next = FBDP_IDLE;
          end else begin
            wait_next = wait_reg - 4'h1;
          end
        end
        default: begin
          state_next = FBDP_IDLE;
        end
      endcase
    end else begin
      // ready stands through the following phase-high take edge
      ready_next = (state_reg == FBDP_IDLE);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= FBDP_IDLE;
      cur_reg <= '0;
      wait_reg <= 4'h0;
      addr_even_reg <= 9'h0;
      addr_odd_reg <= 9'h0;
      ras_n_reg <= 1'b1;
      cas_even_reg <= 4'hf;
      cas_odd_reg <= 4'hf;
      write_en_outer_pair_n_reg <= 1'b1;
      write_en_inner_pair_n_reg <= 1'b1;
      oe_reg <= 4'hf;
      rom_n_reg <= 1'b1;
      dac_n_reg <= 1'b1;
      join_reg <= `FBDP_JOIN_RST;
      dout_reg <= 32'h0;
      drive_reg <= 1'b0;
      drive_lo_reg <= 1'b0;
      ready_reg <= 1'b0;
      rsp_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      wait_reg <= wait_next;
      addr_even_reg <= addr_even_next;
      addr_odd_reg <= addr_odd_next;
      ras_n_reg <= ras_n_next;
      cas_even_reg <= cas_even_next;
      cas_odd_reg <= cas_odd_next;
      write_en_outer_pair_n_reg <= write_en_outer_pair_n_next;
      write_en_inner_pair_n_reg <= write_en_inner_pair_n_next;
      oe_reg <= oe_next;
      rom_n_reg <= rom_n_next;
      dac_n_reg <= dac_n_next;
      join_reg <= join_next;
      dout_reg <= dout_next;
      drive_reg <= drive_next;
      drive_lo_reg <= drive_lo_next;
      ready_reg <= ready_next;
      rsp_reg <= rsp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign req_ready_o = ready_reg;
  assign rsp_valid_o = rsp_reg;
  assign rsp_data_o = rdata_reg;
  assign mem_data_bus_o = dout_reg;
  assign mem_data_bus_oe_o = {{24{drive_reg}}, {8{drive_lo_reg}}};
  assign mem_addr_banks_even_pair_o = addr_even_reg;
  assign mem_addr_banks_odd_pair_o = addr_odd_reg;
  assign row_strobe_n_o = ras_n_reg;
  assign col_strobe_even_pair_n_o = cas_even_reg;
  assign col_strobe_odd_pair_n_o = cas_odd_reg;
  assign write_en_outer_pair_n_o = write_en_outer_pair_n_reg;
  assign write_en_inner_pair_n_o = write_en_inner_pair_n_reg;
  assign out_en_bank_n_o = oe_reg;
  assign boot_rom_select_n_o = rom_n_reg;
  assign dac_select_n_o = dac_n_reg;
  assign wide_port_join_o = join_reg;
endmodule : fbdp_port

// [verilog/fbdp_map.svh]
// fbdp_map.svh: offsets, field positions, reset values and timing counts
// for the four-bank dram port; assumes a 125 MHz core clock on the
// doubled memory clock pin and nothing else.
`ifndef FBDP_MAP_SVH
`define FBDP_MAP_SVH
`define FBDP_ROM_DATA_LSB 0
`define FBDP_ROM_DATA_MSB 7
`define FBDP_DAC_REG_LSB 8
`define FBDP_DAC_REG_MSB 15
`define FBDP_ROM_ADDR_LSB 16
`define FBDP_ROM_ADDR_MSB 30
`define FBDP_ROM_RW_BIT 31
`define FBDP_ROW_LSB 9
`define FBDP_ADDR_W 9
`define FBDP_JOIN_RST 1'b1
`define FBDP_ROM_WAIT 4'h4
`endif

// [verilog/fbdp_pkg.sv]
// fbdp_pkg: request and state types of the four-bank dram port.
// assumes the map header is compiled alongside.
package fbdp_pkg;
  typedef enum logic [2:0] {
    FBDP_IDLE = 3'b000,
    FBDP_ROW = 3'b001,
    FBDP_RAS = 3'b011,
    FBDP_COL = 3'b010,
    FBDP_CAS = 3'b110,
    FBDP_DONE = 3'b111,
    FBDP_ROM = 3'b101
  } fbdp_state_type;

  typedef enum logic [1:0] {
    FBDP_OP_DRAM = 2'h0,
    FBDP_OP_ROM = 2'h1,
    FBDP_OP_DAC_REG = 2'h2,
    FBDP_OP_DAC_PIX = 2'h3
  } fbdp_op_type;

  typedef struct packed {
    fbdp_op_type op;
    logic write;
    logic [1:0] bank;
    logic [17:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } fbdp_req_type;

  typedef struct packed {
    logic [31:0] wdata;
    logic drive;
  } fbdp_bus_out_type;
endpackage : fbdp_pkg

// [verilog/fbdp_clk_half.sv]
// fbdp_clk_half: halves the doubled memory clock into an internal phase.
// assumes clk_i is the doubled memory clock itself.
`timescale 1ns/1ps
module fbdp_clk_half (
  input wire logic clk_i,
  input wire logic resetn_i,
  output logic phase_o
);
  logic phase_reg;
  logic phase_next;

  // toggle every edge; the sequencer steps only on phase high
  always_comb begin
    phase_next = ~phase_reg;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign phase_o = phase_reg;
endmodule : fbdp_clk_half

// [sim/fbdp_port_monitor.sv]
// fbdp_port_monitor: pin timing relations of the dram port.
// assumes binding onto fbdp_port; it only watches, never drives.
`timescale 1ns/1ps
module fbdp_port_monitor
  import fbdp_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  input wire fbdp_req_type req_i,
  input wire logic join_halves_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic [31:0] mem_data_bus_oe_o,
  input wire logic [8:0] mem_addr_banks_even_pair_o,
  input wire logic row_strobe_n_o,
  input wire logic [3:0] col_strobe_even_pair_n_o,
  input wire logic [3:0] col_strobe_odd_pair_n_o,
  input wire logic write_en_outer_pair_n_o,
  input wire logic write_en_inner_pair_n_o,
  input wire logic [3:0] out_en_bank_n_o,
  input wire logic wide_port_join_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // a take needs valid and ready at one edge
  sequence take_dram;
    req_valid_i && req_ready_o && req_i.op == FBDP_OP_DRAM;
  endsequence
  sequence take_slow;
    req_valid_i && req_ready_o && req_i.op != FBDP_OP_DRAM;
  endsequence
  // answer timing is fixed, so a late pulse means a broken sequencer
  AST_RSP_DRAM: assert property (take_dram |-> ##11 rsp_valid_o)
    else $error("dram answer off time");
  AST_RSP_SLOW: assert property (take_slow |-> ##11 rsp_valid_o)
    else $error("rom or dac answer off time");
  AST_JOIN: assert property (join_halves_i |=> !wide_port_join_o)
    else $error("halves not joined");
  AST_ISOL: assert property (!join_halves_i |=> wide_port_join_o)
    else $error("halves not isolated");
  AST_ONE_PAIR: assert property (col_strobe_even_pair_n_o != 4'hf
    |-> col_strobe_odd_pair_n_o == 4'hf)
    else $error("both pairs strobed");
  AST_ROW_SETUP: assert property ($fell(row_strobe_n_o)
    |-> $stable(mem_addr_banks_even_pair_o))
    else $error("row address moved at strobe");
  AST_WE_DRIVE: assert property (!(write_en_outer_pair_n_o
    && write_en_inner_pair_n_o) |-> mem_data_bus_oe_o == 32'hffffffff
    && out_en_bank_n_o == 4'hf)
    else $error("write without drive");
  AST_OE_ONE: assert property ($onehot0(~out_en_bank_n_o))
    else $error("two banks read at once");
endmodule : fbdp_port_monitor

bind fbdp_port fbdp_port_monitor u_mon (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .req_valid_i(req_valid_i),
  .req_i(req_i),
  .join_halves_i(join_halves_i),
  .req_ready_o(req_ready_o),
  .rsp_valid_o(rsp_valid_o),
  .mem_data_bus_oe_o(mem_data_bus_oe_o),
  .mem_addr_banks_even_pair_o(mem_addr_banks_even_pair_o),
  .row_strobe_n_o(row_strobe_n_o),
  .col_strobe_even_pair_n_o(col_strobe_even_pair_n_o),
  .col_strobe_odd_pair_n_o(col_strobe_odd_pair_n_o),
  .write_en_outer_pair_n_o(write_en_outer_pair_n_o),
  .write_en_inner_pair_n_o(write_en_inner_pair_n_o),
  .out_en_bank_n_o(out_en_bank_n_o),
  .wide_port_join_o(wide_port_join_o)
);

// [sim/fbdp_dram_model.sv]
// fbdp_dram_model: four banks of dram plus boot rom on the shared bus.
// assumes pins settle before the falling clock edge it samples on.
`timescale 1ns/1ps
module fbdp_dram_model (
  input wire logic clk_i,
  input wire logic [8:0] ae_i,
  input wire logic [8:0] ao_i,
  input wire logic ras_n_i,
  input wire logic [3:0] ce_n_i,
  input wire logic [3:0] co_n_i,
  input wire logic weo_n_i,
  input wire logic wei_n_i,
  input wire logic [3:0] oe_n_i,
  input wire logic rom_n_i,
  input wire logic [31:0] bus_i,
  output logic [31:0] data_o
);
  logic [31:0] mem [bit [19:0]];
  logic [8:0] row_e, row_o;
  logic [31:0] rdq = 32'h0, pat = 32'h5a5a5a5a;
  logic [3:0] ce_q = 4'hf, co_q = 4'hf;
  function automatic logic [19:0] key(input logic [1:0] b);
    key = b[0] ? {b, row_o, ao_i} : {b, row_e, ae_i};
  endfunction : key
  task automatic wr(input logic [1:0] b, input logic [3:0] ln);
    logic [31:0] v;
    v = mem.exists(key(b)) ? mem[key(b)] : pat;
    for (int j = 0; j < 4; j++) if (ln[j]) v[8*j+:8] = bus_i[8*j+:8];
    mem[key(b)] = v;
  endtask : wr
  // one row strobe latches the row of both pairs
  always @(negedge ras_n_i) begin
    row_e = ae_i;
    row_o = ao_i;
  end
  // bank comes from the strobed pair and the shared write enable
  always @(negedge clk_i) begin
    pat <= ~pat;
    ce_q <= ce_n_i;
    co_q <= co_n_i;
    if (ce_q == 4'hf && ce_n_i != 4'hf && !(weo_n_i && wei_n_i)) begin
      wr(weo_n_i ? 2'd2 : 2'd0, ~ce_n_i);
    end
    if (co_q == 4'hf && co_n_i != 4'hf && !(weo_n_i && wei_n_i)) begin
      wr(wei_n_i ? 2'd3 : 2'd1, ~co_n_i);
    end
    for (int i = 0; i < 4; i++) begin
      if (!oe_n_i[i] && mem.exists(key(2'(i)))) rdq <= mem[key(2'(i))];
    end
  end
  // a released bus toggles so stale data never passes for a read
  assign data_o = (oe_n_i != 4'hf) ? rdq :
    (!rom_n_i ? {pat[31:8], bus_i[23:16] ^ 8'h5a} : pat);
endmodule : fbdp_dram_model

// [sim/four_bank_dram_port_bench.sv]
// four_bank_dram_port_bench: drives the port against the dram model.
// assumes inputs change on the falling edge only.
`timescale 1ns/1ps
module four_bank_dram_port_bench;
  import fbdp_pkg::*;
  logic clk_i = 1'b0, resetn_i = 1'b0, req_valid_i = 1'b0;
  logic join_halves_i = 1'b0;
  fbdp_req_type req_i = '0;
  logic [31:0] mem_data_bus_i, mem_data_bus_o, mem_data_bus_oe_o;
  logic [31:0] rsp_data_o, mdl_data, rd, seen;
  logic [8:0] mem_addr_banks_even_pair_o, mem_addr_banks_odd_pair_o;
  logic [3:0] col_strobe_even_pair_n_o, col_strobe_odd_pair_n_o;
  logic [3:0] out_en_bank_n_o;
  logic req_ready_o, rsp_valid_o, row_strobe_n_o, boot_rom_select_n_o;
  logic write_en_outer_pair_n_o, write_en_inner_pair_n_o;
  logic dac_select_n_o, wide_port_join_o;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  always #4 clk_i = ~clk_i;
  // wire level: the port where it drives, memory or rom elsewhere
  assign mem_data_bus_i = (mem_data_bus_oe_o & mem_data_bus_o)
    | (~mem_data_bus_oe_o & mdl_data);
  fbdp_port DUT (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .req_valid_i(req_valid_i),
    .req_i(req_i),
    .join_halves_i(join_halves_i),
    .mem_data_bus_i(mem_data_bus_i),
    .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o),
    .mem_data_bus_o(mem_data_bus_o),
    .mem_data_bus_oe_o(mem_data_bus_oe_o),
    .mem_addr_banks_even_pair_o(mem_addr_banks_even_pair_o),
    .mem_addr_banks_odd_pair_o(mem_addr_banks_odd_pair_o),
    .row_strobe_n_o(row_strobe_n_o),
    .col_strobe_even_pair_n_o(col_strobe_even_pair_n_o),
    .col_strobe_odd_pair_n_o(col_strobe_odd_pair_n_o),
    .write_en_outer_pair_n_o(write_en_outer_pair_n_o),
    .write_en_inner_pair_n_o(write_en_inner_pair_n_o),
    .out_en_bank_n_o(out_en_bank_n_o),
    .boot_rom_select_n_o(boot_rom_select_n_o),
    .dac_select_n_o(dac_select_n_o),
    .wide_port_join_o(wide_port_join_o)
  );
  fbdp_dram_model u_mem (.clk_i(clk_i), .ae_i(mem_addr_banks_even_pair_o),
    .ao_i(mem_addr_banks_odd_pair_o), .ras_n_i(row_strobe_n_o),
    .ce_n_i(col_strobe_even_pair_n_o), .co_n_i(col_strobe_odd_pair_n_o),
    .weo_n_i(write_en_outer_pair_n_o), .wei_n_i(write_en_inner_pair_n_o),
    .oe_n_i(out_en_bank_n_o), .rom_n_i(boot_rom_select_n_o),
    .bus_i(mem_data_bus_i), .data_o(mdl_data));
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one request; bus seen while rom or dac is selected is kept
  task automatic xfer(input fbdp_op_type op, input logic w,
    input logic [1:0] b, input logic [17:0] a, input logic [3:0] be,
    input logic [31:0] wd, input int lat);
    int n;
    seen = '0;
    req_i = '{op, w, b, a, be, wd};
    req_valid_i = 1'b1;
    do @(negedge clk_i); while (req_ready_o !== 1'b1);
    @(negedge clk_i);
    req_valid_i = 1'b0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 40) begin
      if (!boot_rom_select_n_o || !dac_select_n_o) seen = mem_data_bus_o;
      @(negedge clk_i);
      n++;
    end
    rd = rsp_data_o;
    chk("latency", 32'(lat), 32'(n));
  endtask : xfer
  task automatic t_join;
    @(negedge clk_i) join_halves_i = 1'b1;
    @(negedge clk_i) chk("join low", 32'h0, 32'(wide_port_join_o));
    join_halves_i = 1'b0;
    @(negedge clk_i) chk("join high", 32'h1, 32'(wide_port_join_o));
  endtask : t_join
  // all banks written before any read, so a wrong bank shows
  task automatic t_dram;
    for (int b = 0; b < 4; b++) begin
      xfer(FBDP_OP_DRAM, 1'b1, 2'(b), 18'h2a5a5, 4'hf, 32'h13579b00 | b, 10);
    end
    xfer(FBDP_OP_DRAM, 1'b1, 2'd1, 18'h2a5a5, 4'h2, 32'h0000ee00, 10);
    for (int b = 0; b < 4; b++) begin
      xfer(FBDP_OP_DRAM, 1'b0, 2'(b), 18'h2a5a5, 4'hf, 32'h0, 10);
      chk("dram", b == 1 ? 32'h1357ee01 : 32'h13579b00 | b, rd);
    end
  endtask : t_dram
  task automatic t_rom_dac;
    xfer(FBDP_OP_ROM, 1'b0, 2'd0, 18'h01234, 4'hf, 32'h0, 10);
    chk("rom data", 32'h6e, {24'h0, rd[7:0]});
    chk("rom addr", 32'h1234, {17'h0, seen[30:16]});
    chk("rom read", 32'h1, 32'(seen[31]));
    xfer(FBDP_OP_DAC_REG, 1'b1, 2'd0, 18'h0, 4'hf, 32'h000000a5, 10);
    chk("dac reg", 32'ha5, {24'h0, seen[15:8]});
    xfer(FBDP_OP_DAC_PIX, 1'b1, 2'd0, 18'h0, 4'hf, 32'hcafe1234, 10);
    chk("dac pixel", 32'hcafe1234, seen);
  endtask : t_rom_dac
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  // hang guard, far above the under two hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(negedge clk_i);
    chk("reset join", 32'h1, 32'(wide_port_join_o));
    chk("reset oe", 32'h0, mem_data_bus_oe_o);
    chk("reset row", 32'h1, 32'(row_strobe_n_o));
    resetn_i = 1'b1;
    t_join();
    t_dram();
    t_rom_dac();
    give_verdict();
  end
endmodule : four_bank_dram_port_bench
